// File: hdl/srs_pkg.sv
// Constants shared by the serial register access block.
// Assumes a byte-wide register space of 128 entries, 8 pages of 16.
package srs_pkg;
    localparam int          DATA_W         = 8;
    localparam int          PAGE_W         = 3;
    localparam int          OFFS_W         = 4;
    localparam int          ADDR_W         = PAGE_W + OFFS_W;
    localparam int          REG_NUM        = 1 << ADDR_W;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          FIFO_W         = ADDR_W + DATA_W;
    localparam int          RES_W          = 16;
    localparam logic [6:0]  REG_STREAM_CTL = 7'h03;
    localparam logic [6:0]  REG_RES_HI     = 7'h1a;
    localparam logic [6:0]  REG_RES_LO     = 7'h1b;
    localparam logic [7:0]  INSTR_PAGE     = 8'h10;
    localparam int          INSTR_RD_BIT   = 7;
    localparam int          INSTR_CNT_HI   = 6;
    localparam int          INSTR_CNT_LO   = 5;
    localparam logic [1:0]  CNT_STREAM     = 2'h3;
    localparam int          KIND_BIT       = 7;
    localparam int          SPAN_HI        = 2;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [7:0]  REG_RST_VAL    = 8'h00;
    typedef enum logic [1:0] {
        ST_INSTR = 2'b00,
        ST_PAGE  = 2'b01,
        ST_DATA  = 2'b10
    } srs_state_t;
endpackage

// File: hdl/srs_top.sv
// Serial register access with paged addressing, normal and controlled streaming.
// Assumes a mode-0 serial master clocking well below a sixth of CLK_SYS_IN.
`timescale 1ns/1ns

module srs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             en_in,
    input  wire logic             in_valid_in,
    output wire logic             in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output wire logic             out_valid_out,
    input  wire logic             out_ready_in,
    output wire logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;
    wire              push = en_in & in_valid_in & in_ready_out;
    wire              pop  = en_in & out_valid_out & out_ready_in;

    // Count is one bit wider than the pointers so full and empty stay apart
    assign in_ready_out  = (count_ff < (PW+1)'(DEPTH));
    assign out_valid_out = (count_ff != '0);
    assign out_data_out  = mem_ff[rd_ptr_ff];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            if (pop)  rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // srs_fifo

module srs_top
    import srs_pkg::*;
(
    input  wire logic                    CLK_SYS_IN,
    input  wire logic                    SYS_RST_IN,
    input  wire logic                    CLK_EN_IN,
    input  wire logic                    SCLK_IN,
    input  wire logic                    SELECT_LOW_N_IN,
    input  wire logic                    SDI_IN,
    input  wire logic [srs_pkg::RES_W-1:0] RESULT_IN,
    output logic                         SDO_OUT,
    output logic                         SDO_OE_OUT,
    output logic                         WR_DROP_OUT
);
    import srs_pkg::*;

    // Pin synchronisers, three stages each; stage one feeds stage two only
    logic [2:0] sclk_sy_ff;
    logic [2:0] csb_sy_ff;
    logic [2:0] sdi_sy_ff;
    logic       sclk_lvl_ff;
    logic       csb_lvl_ff;

    srs_state_t        state_ff;
    logic [2:0]        bit_cnt_ff;
    logic [6:0]        rx_ff;
    logic [7:0]        tx_ff;
    logic [PAGE_W-1:0] page_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] start_ff;
    logic [1:0]        left_ff;
    logic              rd_ff;
    logic              stream_ff;
    logic [7:0]        regs_ff [REG_NUM];

    wire sclk_agree = (sclk_sy_ff[1] == sclk_sy_ff[2]);
    wire csb_agree  = (csb_sy_ff[1] == csb_sy_ff[2]);
    wire sclk_rise  = CLK_EN_IN & sclk_agree & sclk_sy_ff[2] & ~sclk_lvl_ff;
    wire sclk_fall  = CLK_EN_IN & sclk_agree & ~sclk_sy_ff[2] & sclk_lvl_ff;
    wire cs_active  = ~csb_lvl_ff;
    wire cs_end     = CLK_EN_IN & csb_agree & csb_sy_ff[2] & ~csb_lvl_ff;
    wire sdi_agree  = (sdi_sy_ff[1] == sdi_sy_ff[2]);
    wire sdi_bit    = sdi_agree ? sdi_sy_ff[2] : rx_ff[0];

    wire       bit_take  = sclk_rise & cs_active;
    wire       byte_done = bit_take & (bit_cnt_ff == BIT_LAST);
    wire [7:0] rx_byte   = {rx_ff, sdi_bit};

    // Stream control steers addressing straight from the register array
    wire [7:0]        stream_ctl = regs_ff[REG_STREAM_CTL];
    wire              kind       = stream_ctl[KIND_BIT];
    wire [ADDR_W-1:0] span       = ADDR_W'(stream_ctl[SPAN_HI:0]);
    wire [ADDR_W-1:0] win_end    = start_ff + span;
    wire              at_wrap    = kind & (addr_ff == win_end);
    wire [ADDR_W-1:0] nxt_addr   = at_wrap ? start_ff : addr_ff + 1'b1;

    wire              is_instr   = (state_ff == ST_INSTR);
    wire              is_page    = is_instr & (rx_byte == INSTR_PAGE);
    wire [ADDR_W-1:0] instr_addr = {page_ff, rx_byte[OFFS_W-1:0]};
    wire              last_data  = ~stream_ff & (left_ff == 2'h0);
    wire              instr_rd   = rx_byte[INSTR_RD_BIT];
    wire [ADDR_W-1:0] fetch_addr = is_instr ? instr_addr : nxt_addr;
    wire [7:0]        fetch_val  = (fetch_addr == REG_RES_HI) ? RESULT_IN[RES_W-1:DATA_W] :
                                   (fetch_addr == REG_RES_LO) ? RESULT_IN[DATA_W-1:0] :
                                   regs_ff[fetch_addr];
    wire load_first = byte_done & is_instr & ~is_page & instr_rd;
    wire load_next  = byte_done & (state_ff == ST_DATA) & rd_ff & ~last_data;
    wire tx_load    = load_first | load_next;

    // Write path through the FIFO; a full FIFO drops the byte and flags it
    wire              push_req = byte_done & (state_ff == ST_DATA) & ~rd_ff;
    wire              fifo_in_ready;
    wire              fifo_out_valid;
    wire [FIFO_W-1:0] fifo_out_data;
    wire [ADDR_W-1:0] drain_addr = fifo_out_data[FIFO_W-1:DATA_W];
    // Draining pauses on a read fetch so the array sees one access per cycle
    wire              drain_ready = ~tx_load;
    wire              drain_go    = CLK_EN_IN & fifo_out_valid & drain_ready;
    wire              drain_ro    = (drain_addr == REG_RES_HI) | (drain_addr == REG_RES_LO);

    srs_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_in        (CLK_SYS_IN),
        .rst_in        (SYS_RST_IN),
        .en_in         (CLK_EN_IN),
        .in_valid_in   (push_req),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    ({addr_ff, rx_byte}),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (drain_ready),
        .out_data_out  (fifo_out_data)
    );

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            for (int i = 0; i < REG_NUM; i++) begin
                regs_ff[i] <= REG_RST_VAL;
            end
        end else if (drain_go && !drain_ro) begin
            regs_ff[drain_addr] <= fifo_out_data[DATA_W-1:0];
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            sclk_sy_ff  <= 3'h0;
            csb_sy_ff   <= 3'h7;
            sdi_sy_ff   <= 3'h0;
            sclk_lvl_ff <= 1'b0;
            csb_lvl_ff  <= 1'b1;
        end else if (CLK_EN_IN) begin
            sclk_sy_ff <= {sclk_sy_ff[1:0], SCLK_IN};
            csb_sy_ff  <= {csb_sy_ff[1:0], SELECT_LOW_N_IN};
            sdi_sy_ff  <= {sdi_sy_ff[1:0], SDI_IN};
            if (sclk_agree) sclk_lvl_ff <= sclk_sy_ff[2];
            if (csb_agree)  csb_lvl_ff  <= csb_sy_ff[2];
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN || cs_end || !cs_active) begin
            bit_cnt_ff <= 3'h0;
            rx_ff      <= 7'h00;
        end else if (bit_take) begin
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
            rx_ff      <= rx_byte[6:0];
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            state_ff  <= ST_INSTR;
            page_ff   <= '0;
            addr_ff   <= '0;
            start_ff  <= '0;
            left_ff   <= 2'h0;
            rd_ff     <= 1'b0;
            stream_ff <= 1'b0;
        end else if (cs_end) begin
            state_ff <= ST_INSTR;
        end else if (byte_done) begin
            case (state_ff)
                ST_INSTR: begin
                    if (is_page) begin
                        state_ff <= ST_PAGE;
                    end else begin
                        state_ff  <= ST_DATA;
                        rd_ff     <= instr_rd;
                        stream_ff <= (rx_byte[INSTR_CNT_HI:INSTR_CNT_LO] == CNT_STREAM);
                        left_ff   <= rx_byte[INSTR_CNT_HI:INSTR_CNT_LO];
                        addr_ff   <= instr_addr;
                        start_ff  <= instr_addr;
                    end
                end
                ST_PAGE: begin
                    page_ff  <= rx_byte[PAGE_W-1:0];
                    state_ff <= ST_INSTR;
                end
                ST_DATA: begin
                    addr_ff <= nxt_addr;
                    left_ff <= left_ff - 1'b1;
                    if (last_data) state_ff <= ST_INSTR;
                end
                default: state_ff <= ST_INSTR;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            tx_ff       <= 8'h00;
            SDO_OUT     <= 1'b0;
            SDO_OE_OUT  <= 1'b0;
            WR_DROP_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            SDO_OE_OUT <= cs_active & ~cs_end & rd_ff & (state_ff == ST_DATA);
            if (tx_load) begin
                tx_ff <= fetch_val;
            end else if (sclk_fall && cs_active) begin
                SDO_OUT <= tx_ff[7];
                tx_ff   <= {tx_ff[6:0], 1'b0};
            end
            // Sticky until reset so a lost byte cannot go unnoticed
            if (push_req && !fifo_in_ready) WR_DROP_OUT <= 1'b1;
        end
    end

    sequence s_data_byte;
        byte_done && state_ff == ST_DATA && !cs_end;
    endsequence

    chk_wr_incr: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        s_data_byte and !rd_ff && !kind |=> addr_ff == $past(addr_ff) + 1'b1)
        else $error("write address did not advance");
    chk_cs_end_idle: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        cs_end |=> state_ff == ST_INSTR ##1 state_ff == ST_INSTR)
        else $error("select release did not end the access");
    chk_page_hold: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !(byte_done && state_ff == ST_PAGE) |=> page_ff == $past(page_ff))
        else $error("upper page changed without setup");
    chk_rd_first: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        load_first && !cs_end |=> tx_ff == $past(fetch_val) && rd_ff)
        else $error("first read byte not fetched");
    chk_reset_normal: assert property (@(posedge CLK_SYS_IN)
        SYS_RST_IN |=> !kind && state_ff == ST_INSTR)
        else $error("reset did not select normal streaming");
    chk_stream_run: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        s_data_byte and stream_ff |=> state_ff == ST_DATA)
        else $error("stream ended without select release");
    chk_wrap_start: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        s_data_byte and at_wrap |=> addr_ff == $past(start_ff))
        else $error("controlled stream did not wrap");
    chk_result_hi: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        load_first && instr_addr == REG_RES_HI |=> tx_ff == $past(RESULT_IN[RES_W-1:DATA_W]))
        else $error("result high byte not at its address");
    chk_full_addr: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        byte_done && is_instr && !is_page && !cs_end
        |=> addr_ff == {$past(page_ff), $past(rx_byte[OFFS_W-1:0])})
        else $error("address not page joined with offset");

    // Read phase: fetch edge, then one edge for the enable to follow the state
    sequence s_read_start;
        load_first && !cs_end ##1 CLK_EN_IN && !cs_end;
    endsequence

    chk_oe_read: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        s_read_start |=> SDO_OE_OUT)
        else $error("data out not enabled in read phase");
    chk_span_wrap: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        s_data_byte and kind && (addr_ff - start_ff) == ADDR_W'(stream_ctl[SPAN_HI:0])
        |=> addr_ff == $past(start_ff))
        else $error("window end not start plus span");
    chk_sel_stop: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        cs_end |=> state_ff == ST_INSTR && !SDO_OE_OUT)
        else $error("select release did not stop the stream");
    chk_page_enter: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        byte_done && is_page && !cs_end |=> state_ff == ST_PAGE)
        else $error("page setup instruction not taken");
    chk_result_lo: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        load_first && instr_addr == REG_RES_LO |=> tx_ff == $past(RESULT_IN[DATA_W-1:0]))
        else $error("result low byte not at its address");
endmodule // srs_top

// File: verification/srs_host_model.sv
// Serial host master model: mode 0, MSB first, one frame per select-low period.
// Assumes the bench calls its tasks and that clk_in is the device's system clock.
`timescale 1ns/1ns

module srs_host_model (
    input  wire logic clk_in,
    input  wire logic sdo_in,
    output logic      sclk_out,
    output logic      sel_n_out,
    output logic      sdi_out
);
    // Each phase is kept above the four-clock minimum of the device's pin filter
    localparam int HALF = 6;

    // The serial clock stands low outside frames
    initial begin
        sclk_out  = 1'b0;
        sel_n_out = 1'b1;
        sdi_out   = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic frame_start();
        sel_n_out = 1'b0;
        wait_clk(HALF);
    endtask

    // Released data line is flipped so that a stale value is never mistaken for data
    task automatic frame_end();
        wait_clk(HALF);
        sel_n_out = 1'b1;
        sdi_out   = ~sdi_out;
        wait_clk(HALF);
    endtask

    // Data is set while the clock is low; the answer is taken just before the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi_out = tx[i];
            wait_clk(HALF);
            rx[i]    = sdo_in;
            sclk_out = 1'b1;
            wait_clk(HALF);
            sclk_out = 1'b0;
        end
    endtask
endmodule // srs_host_model

// File: verification/tb_top.sv
// Self-checking bench: register accesses through the serial host model.
// Assumes the design's package and the host model are compiled first.
`timescale 1ns/1ns

module tb_top;
    import srs_pkg::*;
    logic             clk_sys;
    logic             sys_rst;
    logic             clk_en;
    logic             sclk;
    logic             sel_n;
    logic             sdi;
    logic             sdo;
    logic             sdo_oe;
    logic             wr_drop;
    logic             oe_mid;
    logic [RES_W-1:0] result;
    logic [7:0]       tx [16];
    logic [7:0]       rx [16];
    int               err_total   = 0;
    int               checks_done = 0;

    srs_top srs_top_i (.CLK_SYS_IN(clk_sys), .SYS_RST_IN(sys_rst), .CLK_EN_IN(clk_en),
        .SCLK_IN(sclk), .SELECT_LOW_N_IN(sel_n), .SDI_IN(sdi), .RESULT_IN(result),
        .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .WR_DROP_OUT(wr_drop));
    srs_host_model srs_host_model_i (.clk_in(clk_sys), .sdo_in(sdo), .sclk_out(sclk),
        .sel_n_out(sel_n), .sdi_out(sdi));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, want);
        end
    endtask

    // Page byte is sent only when asked, since the device keeps the last page
    task automatic access(input logic rd, input logic setp, input logic [6:0] addr,
                          input int n);
        logic [7:0] junk;
        logic [1:0] cnt;
        cnt = (n > 3) ? CNT_STREAM : 2'(n - 1);
        srs_host_model_i.frame_start();
        if (setp) begin
            srs_host_model_i.xfer(INSTR_PAGE, junk);
            srs_host_model_i.xfer({5'h00, addr[6:4]}, junk);
        end
        srs_host_model_i.xfer({rd, cnt, 1'b0, addr[3:0]}, junk);
        if (rd) oe_mid = sdo_oe;
        for (int i = 0; i < n; i++) begin
            srs_host_model_i.xfer(rd ? 8'h00 : tx[i], rx[i]);
        end
        srs_host_model_i.frame_end();
    endtask

    initial begin
        sys_rst = 1'b1;
        clk_en  = 1'b1;
        result  = 16'hc35a;
        for (int i = 0; i < 16; i++) begin
            tx[i] = 8'(8'h11 * (i + 1));
        end
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        access(1'b1, 1'b1, REG_STREAM_CTL, 1);
        check(rx[0], REG_RST_VAL);
        access(1'b0, 1'b1, 7'h1f, 3);
        tx[0] = 8'h9c;
        access(1'b0, 1'b0, 7'h12, 1);
        access(1'b1, 1'b0, 7'h1f, 3);
        check(rx[0], 8'h11);
        check(rx[1], 8'h22);
        check(rx[2], 8'h33);
        access(1'b1, 1'b0, 7'h12, 1);
        check(rx[0], 8'h9c);
        tx[0] = 8'hff;
        tx[1] = 8'hff;
        access(1'b0, 1'b0, REG_RES_HI, 2);
        access(1'b1, 1'b0, REG_RES_HI, 2);
        check(rx[0], result[15:8]);
        check(rx[1], result[7:0]);
        for (int i = 0; i < 6; i++) begin
            tx[i] = 8'(8'ha1 + 8'(i * 3));
        end
        access(1'b0, 1'b1, 7'h28, 6);
        access(1'b1, 1'b0, 7'h28, 6);
        for (int i = 0; i < 6; i++) begin
            check(rx[i], 8'(8'ha1 + 8'(i * 3)));
        end
        tx[0] = 8'h81;
        access(1'b0, 1'b1, REG_STREAM_CTL, 1);
        result = 16'h7e18;
        access(1'b1, 1'b1, REG_RES_HI, 8);
        for (int i = 0; i < 8; i++) begin
            check(rx[i], i[0] ? result[7:0] : result[15:8]);
        end
        check({7'h00, oe_mid}, 8'h01);
        access(1'b1, 1'b0, 7'h12, 3);
        check(rx[0], 8'h9c);
        check(rx[1], 8'h00);
        check(rx[2], 8'h9c);
        // A frame sent while the enable is low must leave no trace
        clk_en = 1'b0;
        tx[0]  = 8'h55;
        access(1'b0, 1'b0, 7'h12, 1);
        clk_en = 1'b1;
        access(1'b1, 1'b0, 7'h12, 1);
        check(rx[0], 8'h9c);
        access(1'b1, 1'b0, REG_RES_LO, 1);
        check(rx[0], result[7:0]);
        check({7'h00, sdo_oe}, 8'h00);
        check({7'h00, wr_drop}, 8'h00);
        tally_and_finish();
    end

    // Whole sequence needs roughly 6500 cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        tally_and_finish();
    end
endmodule // tb_top
